// ---- core/dmx_exec.sv ----
// Execution unit for the four data move instructions.
// Assumes program memory presents each word during Q4 of the prior
// cycle and data memory answers reads within the Q2 quarter.
// Notes on behaviour
// - Two-word move: source word then destination
// - Source reaches whole 4096-byte space, no banking
// - Destination reaches whole space, ignoring bank
// - Working register usable through its mapped address
// - Two cycles; read Q2 first, write Q4 second
// - Bank literal load written in Q4
// - Bank upper nibble always forced to zero
// - Working literal load, one cycle, flags kept
// - Store working to file: read Q2, write Q4
// - File field picks byte within bank
// - Access bit zero access bank, one banked
// - Extended set, low field: indexed literal offset
// - Indexed mode adds field to index base
`timescale 1ns/10ps
`include "dmx_cfg.svh"
module dmx_exec
   import dmx_pkg::*;
(
   input  wire logic        i_clk,          // Core clock, 100 MHz
   input  wire logic        i_arst_n,       // Async reset, active low
   input  wire logic [15:0] i_instr,        // Instruction word, Q4
   input  wire logic        i_skip,         // Flush this word, Q4
   input  wire logic        i_ext_en,       // Extended set enabled
   input  wire logic [11:0] i_index_base,   // Indexed offset base
   input  wire logic [7:0]  i_dmem_rdata,   // Data memory read data
   output logic [11:0]      o_dmem_addr,    // Data memory address
   output logic             o_dmem_rd,      // Read strobe, Q2
   output logic             o_dmem_we,      // Write strobe, Q4
   output logic [7:0]       o_dmem_wdata,   // Write data
   output logic [7:0]       o_working,      // Working register
   output logic [7:0]       o_bank_select,  // Bank select register
   output logic             o_fetch,        // Word sampled this clock
   output logic             o_second_word   // Move second cycle
);
   dmx_core_if u_if ();

   dmx_qphase u_phase (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .bus      (u_if)
   );

   dmx_addr_former u_addr (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .bus      (u_if)
   );

   dmx_st_t     st;
   dmx_st_t     next_st;
   logic [15:0] ir;
   logic [15:0] next_ir;
   logic        skip;
   logic        next_skip;
   logic [7:0]  hold;
   logic [7:0]  next_hold;
   logic [7:0]  work;
   logic [7:0]  next_work;
   logic [7:0]  bank_select_reg;
   logic [7:0]  next_bank_select_reg;
   logic [11:0] dmem_addr;
   logic [11:0] next_dmem_addr;
   logic        dmem_rd;
   logic        next_dmem_rd;
   logic        dmem_we;
   logic        next_dmem_we;
   logic [7:0]  dmem_wdata;
   logic [7:0]  next_dmem_wdata;

   logic        live;
   logic        is_move_src;
   logic        is_move_dst;
   logic        is_ldbank;
   logic        is_ldwork;
   logic        is_stwork;
   logic [11:0] file_addr;
   logic        file_is_w;
   logic        eff_is_w;

   // Operand routing to the address former
   assign u_if.f          = ir[7:0];
   assign u_if.a          = ir[`DMX_ACCESS_BIT];
   assign u_if.ext_en     = i_ext_en;
   assign u_if.bank       = bank_select_reg;
   assign u_if.index_base = i_index_base;

   // Decode; a flushed word decodes to nothing, except is_move_dst, which ignores skip
   assign live        = (st == ST_DECODE) && !skip;
   assign is_move_src = live
      && (ir[`DMX_OP4_HI:`DMX_OP4_LO] == `DMX_OP_MOVE_SRC);
   assign is_move_dst = (st == ST_DECODE)
      && (ir[`DMX_OP4_HI:`DMX_OP4_LO] == `DMX_OP_MOVE_DST);
   assign is_ldbank   = live
      && (ir[`DMX_OP4_HI:`DMX_OP8_LO] == `DMX_OP_LDBANK);
   assign is_ldwork   = live
      && (ir[`DMX_OP4_HI:`DMX_OP8_LO] == `DMX_OP_LDWORK);
   assign is_stwork   = live
      && (ir[`DMX_OP4_HI:`DMX_OP7_LO] == `DMX_OP_STWORK);
   // Full 12-bit operand, bank never consulted
   assign file_addr   = ir[11:0];
   assign file_is_w   = (file_addr == `DMX_WREG_ADDR);
   assign eff_is_w    = (u_if.eff_addr == `DMX_WREG_ADDR);

   always_comb begin
      next_st              = st;
      next_ir              = ir;
      next_skip            = skip;
      next_hold            = hold;
      next_work            = work;
      next_bank_select_reg = bank_select_reg;
      next_dmem_addr       = dmem_addr;
      next_dmem_rd         = 1'b0;
      next_dmem_we         = 1'b0;
      next_dmem_wdata      = dmem_wdata;
      case (u_if.q)
         Q1: begin
            // Arm the Q2 read
            if (is_move_src && !file_is_w) begin
               next_dmem_rd   = 1'b1;
               next_dmem_addr = file_addr;
            end else if (is_stwork) begin
               next_dmem_rd   = 1'b1;
               next_dmem_addr = u_if.eff_addr;
            end
         end
         Q2: begin
            // Latch the source byte at the end of Q2
            if (is_move_src) begin
               next_hold = file_is_w ? work : i_dmem_rdata;
            end
         end
         Q3: begin
            // Arm the Q4 write
            if (st == ST_SECOND && !file_is_w) begin
               next_dmem_we    = 1'b1;
               next_dmem_addr  = file_addr;
               next_dmem_wdata = hold;
            end else if (is_stwork && !eff_is_w) begin
               next_dmem_we    = 1'b1;
               next_dmem_addr  = u_if.eff_addr;
               next_dmem_wdata = work;
            end
         end
         Q4: begin
            if (st == ST_SECOND && file_is_w) begin
               next_work = hold;
            end else if (is_ldwork) begin
               next_work = ir[7:0];
            end else if (is_ldbank) begin
               next_bank_select_reg = {`DMX_BANK_UPPER, ir[3:0]};
            end
            // A lone destination word falls through as a no-op
            if (is_move_src) begin
               next_st = ST_SECOND;
            end else begin
               next_st = ST_DECODE;
            end
            next_ir   = i_instr;
            next_skip = i_skip;
         end
         default: begin
            next_st = ST_DECODE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st              <= ST_DECODE;
         ir              <= `DMX_IR_RST;
         skip            <= 1'b0;
         hold            <= `DMX_DATA_RST;
         work            <= `DMX_WORK_RST;
         bank_select_reg <= `DMX_BANK_RST;
         dmem_addr       <= `DMX_ADDR_RST;
         dmem_rd         <= 1'b0;
         dmem_we         <= 1'b0;
         dmem_wdata      <= `DMX_DATA_RST;
      end else begin
         st              <= next_st;
         ir              <= next_ir;
         skip            <= next_skip;
         hold            <= next_hold;
         work            <= next_work;
         bank_select_reg <= next_bank_select_reg;
         dmem_addr       <= next_dmem_addr;
         dmem_rd         <= next_dmem_rd;
         dmem_we         <= next_dmem_we;
         dmem_wdata      <= next_dmem_wdata;
      end
   end

   assign o_dmem_addr   = dmem_addr;
   assign o_dmem_rd     = dmem_rd;
   assign o_dmem_we     = dmem_we;
   assign o_dmem_wdata  = dmem_wdata;
   assign o_working     = work;
   assign o_bank_select = bank_select_reg;
   assign o_fetch       = (u_if.q == Q4);
   assign o_second_word = (st == ST_SECOND);

   property p_move_src_read;
      @(posedge i_clk) disable iff (!i_arst_n)
      (u_if.q == Q2 && is_move_src && !file_is_w)
      |-> o_dmem_rd && (o_dmem_addr == file_addr);
   endproperty
   a_move_src_read: assert property (p_move_src_read)
      else $error("Move source not read in Q2");

   property p_move_two_cycles;
      @(posedge i_clk) disable iff (!i_arst_n)
      (u_if.q == Q4 && is_move_src)
      |=> (st == ST_SECOND) [*4] ##1 (st == ST_DECODE);
   endproperty
   a_move_two_cycles: assert property (p_move_two_cycles)
      else $error("Move does not take two cycles");

   property p_move_dst_write;
      @(posedge i_clk) disable iff (!i_arst_n)
      (u_if.q == Q4 && st == ST_SECOND && !file_is_w)
      |-> o_dmem_we && (o_dmem_addr == file_addr)
          && (o_dmem_wdata == hold);
   endproperty
   a_move_dst_write: assert property (p_move_dst_write)
      else $error("Move destination not written in Q4");

   property p_move_carries_byte;
      @(posedge i_clk) disable iff (!i_arst_n)
      (u_if.q == Q2 && is_move_src && !file_is_w)
      |-> ##6 (o_dmem_wdata == $past(i_dmem_rdata, 6)) || file_is_w;
   endproperty
   a_move_carries_byte: assert property (p_move_carries_byte)
      else $error("Move wrote a different byte");

   property p_no_dummy_read;
      @(posedge i_clk) disable iff (!i_arst_n)
      (st == ST_SECOND) |-> !o_dmem_rd;
   endproperty
   a_no_dummy_read: assert property (p_no_dummy_read)
      else $error("Dummy read in second move cycle");

   property p_w_as_dest;
      @(posedge i_clk) disable iff (!i_arst_n)
      (u_if.q == Q4 && st == ST_SECOND && file_is_w)
      |-> !o_dmem_we ##1 (work == $past(hold));
   endproperty
   a_w_as_dest: assert property (p_w_as_dest)
      else $error("Working register not moved into");

   property p_bank_load;
      @(posedge i_clk) disable iff (!i_arst_n)
      (u_if.q == Q4 && is_ldbank)
      |=> (bank_select_reg == {4'h0, $past(ir[3:0])});
   endproperty
   a_bank_load: assert property (p_bank_load)
      else $error("Bank literal not loaded");

   property p_bank_upper_zero;
      @(posedge i_clk) disable iff (!i_arst_n)
      bank_select_reg[7:4] == 4'h0;
   endproperty
   a_bank_upper_zero: assert property (p_bank_upper_zero)
      else $error("Bank upper nibble not zero");

   property p_work_load;
      @(posedge i_clk) disable iff (!i_arst_n)
      (u_if.q == Q4 && is_ldwork) |=> (work == $past(ir[7:0]));
   endproperty
   a_work_load: assert property (p_work_load)
      else $error("Working literal not loaded");

   property p_store_work;
      @(posedge i_clk) disable iff (!i_arst_n)
      (u_if.q == Q4 && is_stwork && !eff_is_w)
      |-> o_dmem_we && (o_dmem_wdata == work)
          && (o_dmem_addr == u_if.eff_addr) && $past(o_dmem_rd, 2);
   endproperty
   a_store_work: assert property (p_store_work)
      else $error("Store to file not done in Q4");

   property p_lone_dst_nop;
      @(posedge i_clk) disable iff (!i_arst_n)
      (u_if.q == Q1 && is_move_dst)
      |-> (!o_dmem_we && !o_dmem_rd) [*4] ##1 $stable(work)
          && (st == ST_DECODE);
   endproperty
   a_lone_dst_nop: assert property (p_lone_dst_nop)
      else $error("Lone destination word had an effect");
endmodule // dmx_exec

// ---- include/dmx_cfg.svh ----
// Constants for the data move execution unit.
// Assumes inclusion by bare name from the design files.
`ifndef DMX_CFG_SVH
`define DMX_CFG_SVH

// Opcode fields
`define DMX_OP_MOVE_SRC   4'hc
`define DMX_OP_MOVE_DST   4'hf
`define DMX_OP_LDBANK     8'h01
`define DMX_OP_LDWORK     8'h0e
`define DMX_OP_STWORK     7'h37

// Field positions of an instruction word
`define DMX_OP4_HI        15
`define DMX_OP4_LO        12
`define DMX_OP8_LO        8
`define DMX_OP7_LO        9
`define DMX_ACCESS_BIT    8

// Data space layout
`define DMX_WREG_ADDR     12'hff0
`define DMX_IDX_MAX       8'h5f
`define DMX_ACCESS_SPLIT  8'h60
`define DMX_ACCESS_HI     4'hf
`define DMX_ACCESS_LO     4'h0
`define DMX_BANK_UPPER    4'h0

// Reset values
`define DMX_WORK_RST      8'h00
`define DMX_BANK_RST      8'h00
`define DMX_IR_RST        16'h0000
`define DMX_ADDR_RST      12'h000
`define DMX_DATA_RST      8'h00

`endif

// ---- include/dmx_pkg.sv ----
// Types shared by the data move execution unit.
// Assumes nothing of its surroundings.
package dmx_pkg;
   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} dmx_q_t;
   typedef enum logic {ST_DECODE, ST_SECOND} dmx_st_t;
endpackage

// ---- include/dmx_core_if.sv ----
// Internal carrier between the execution unit and its helpers.
// Assumes dmx_pkg is compiled first.
`timescale 1ns/10ps
interface dmx_core_if;
   import dmx_pkg::*;
   dmx_q_t      q;
   logic [7:0]  f;
   logic        a;
   logic        ext_en;
   logic [7:0]  bank;
   logic [11:0] index_base;
   logic [11:0] eff_addr;
   logic        indexed;
   modport seq  (output q);
   modport addr (input f, a, ext_en, bank, index_base,
                 output eff_addr, indexed);
   modport core (input q, eff_addr, indexed,
                 output f, a, ext_en, bank, index_base);
endinterface

// ---- core/dmx_qphase.sv ----
// Quarter phase sequencer: four clocks make one instruction cycle.
// Assumes a free running clock and asynchronous active low reset.
`timescale 1ns/10ps
module dmx_qphase
   import dmx_pkg::*;
(
   input wire logic i_clk,     // Core clock
   input wire logic i_arst_n,  // Async reset, active low
   dmx_core_if.seq  bus        // Phase out
);
   dmx_q_t q;
   dmx_q_t next_q;

   always_comb begin
      case (q)
         Q1:      next_q = Q2;
         Q2:      next_q = Q3;
         Q3:      next_q = Q4;
         Q4:      next_q = Q1;
         default: next_q = Q1;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q <= Q1;
      end else begin
         q <= next_q;
      end
   end

   assign bus.q = q;

   property p_phase_order;
      @(posedge i_clk) disable iff (!i_arst_n)
      (q == Q1) |=> (q == Q2) ##1 (q == Q3) ##1 (q == Q4) ##1 (q == Q1);
   endproperty
   a_phase_order: assert property (p_phase_order)
      else $error("Quarter phases out of order");
endmodule // dmx_qphase

// ---- core/dmx_addr_former.sv ----
// Effective address former for banked file operands.
// Assumes bank upper nibble is zero and operands stable per cycle.
`timescale 1ns/10ps
`include "dmx_cfg.svh"
module dmx_addr_former
   import dmx_pkg::*;
(
   input wire logic i_clk,     // Core clock, checks only
   input wire logic i_arst_n,  // Async reset, active low
   dmx_core_if.addr bus        // Operand in, address out
);
   logic [11:0] offset_sum;

   assign offset_sum  = bus.index_base + {4'h0, bus.f};
   assign bus.indexed = bus.ext_en && !bus.a
                        && (bus.f <= `DMX_IDX_MAX);

   always_comb begin
      if (bus.indexed) begin
         bus.eff_addr = offset_sum;
      end else if (bus.a) begin
         bus.eff_addr = {bus.bank[3:0], bus.f};
      end else if (bus.f < `DMX_ACCESS_SPLIT) begin
         bus.eff_addr = {`DMX_ACCESS_LO, bus.f};
      end else begin
         bus.eff_addr = {`DMX_ACCESS_HI, bus.f};
      end
   end

   property p_indexed_offset;
      @(posedge i_clk) disable iff (!i_arst_n)
      (bus.ext_en && !bus.a && bus.f <= `DMX_IDX_MAX)
      |-> (bus.eff_addr == 12'(bus.index_base + {4'h0, bus.f}));
   endproperty
   a_indexed_offset: assert property (p_indexed_offset)
      else $error("Indexed offset address wrong");

   property p_banked_select;
      @(posedge i_clk) disable iff (!i_arst_n)
      bus.a |-> (bus.eff_addr == {bus.bank[3:0], bus.f}) && !bus.indexed;
   endproperty
   a_banked_select: assert property (p_banked_select)
      else $error("Banked address wrong");
endmodule // dmx_addr_former

// ---- testbench/dmx_mem_model.sv ----
// Data memory partner: 4096 bytes, combinational read, Q4 write.
// Assumes strobes come from the execution unit's data port.
`timescale 1ns/10ps
module dmx_mem_model (
   input  wire logic        i_clk,    // Core clock
   input  wire logic [11:0] i_addr,   // Byte address
   input  wire logic        i_rd,     // Read strobe
   input  wire logic        i_we,     // Write strobe
   input  wire logic [7:0]  i_wdata,  // Write data
   output logic [7:0]       o_rdata   // Read data
);
   logic [7:0] mem [4096];
   logic [7:0] last;

   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
      last = 8'h00;
   end

   // Answers within the read clock, garbage otherwise
   assign o_rdata = i_rd ? mem[i_addr] : ~last;

   always @(posedge i_clk) begin
      if (i_rd) last <= mem[i_addr];
      if (i_we) mem[i_addr] <= i_wdata;
   end
endmodule // dmx_mem_model

// ---- testbench/test_data_move_instruction_exec.sv ----
// Self-checking bench for the data move execution unit.
// Assumes dmx_pkg, dmx_core_if and the core files compiled first.
`timescale 1ns/10ps
module test_data_move_instruction_exec;
   logic        i_clk = 1'b0;
   logic        i_arst_n = 1'b0;
   logic [15:0] i_instr = 16'h0000;
   logic        i_skip = 1'b0;
   logic        i_ext_en = 1'b0;
   logic [11:0] i_index_base = 12'h000;
   logic [7:0]  i_dmem_rdata;
   logic [11:0] o_dmem_addr;
   logic        o_dmem_rd;
   logic        o_dmem_we;
   logic [7:0]  o_dmem_wdata;
   logic [7:0]  o_working;
   logic [7:0]  o_bank_select;
   logic        o_fetch;
   logic        o_second_word;
   logic [20:0] exp_q [$];
   logic [20:0] e;
   logic [20:0] w_got;
   logic [7:0]  shadow [4096];
   logic [7:0]  w_exp;
   logic [7:0]  lfsr = 8'h22;
   int          n_fail = 0;
   int          checks = 0;

   always #5 i_clk = ~i_clk;

   dmx_exec dmx_exec_inst (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_instr(i_instr),
      .i_skip(i_skip), .i_ext_en(i_ext_en),
      .i_index_base(i_index_base), .i_dmem_rdata(i_dmem_rdata),
      .o_dmem_addr(o_dmem_addr), .o_dmem_rd(o_dmem_rd),
      .o_dmem_we(o_dmem_we), .o_dmem_wdata(o_dmem_wdata),
      .o_working(o_working), .o_bank_select(o_bank_select),
      .o_fetch(o_fetch), .o_second_word(o_second_word));

   dmx_mem_model dmx_mem_model_inst (
      .i_clk(i_clk), .i_addr(o_dmem_addr), .i_rd(o_dmem_rd),
      .i_we(o_dmem_we), .i_wdata(o_dmem_wdata), .o_rdata(i_dmem_rdata));

   function automatic logic [7:0] next_rand(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task test_done();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Present a word in the Q4 clock so it is taken at its end
   task send(input logic [15:0] w, input logic s);
      do begin
         @(posedge i_clk);
         #1;
      end while (o_fetch !== 1'b1);
      i_instr = w;
      i_skip  = s;
   endtask

   task ldw(input logic [7:0] k);
      send({8'h0e, k}, 1'b0);
      w_exp = k;
   endtask

   task store(input logic a, input logic [7:0] f, input logic [11:0] ea);
      send({7'h37, a, f}, 1'b0);
      exp_q.push_back({1'b0, ea, w_exp});
      shadow[ea] = w_exp;
   endtask

   task move(input logic [11:0] s, input logic [11:0] d);
      logic [7:0] v;
      v = (s == 12'hff0) ? w_exp : shadow[s];
      send({4'hc, s}, 1'b0);
      send({4'hf, d}, 1'b0);
      if (d == 12'hff0) begin
         w_exp = v;
      end else begin
         exp_q.push_back({1'b1, d, v});
         shadow[d] = v;
      end
   endtask

   task check(input logic [7:0] got, input logic [7:0] want);
      checks++;
      if (got !== want) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, want);
      end
   endtask

   // Each write must match the oldest note, in Q4, mid clock
   always @(negedge i_clk) begin
      if (o_dmem_we === 1'b1) begin
         checks++;
         if (exp_q.size() == 0) begin
            n_fail++;
            $display("BAD %0t stray write %h %h", $time, o_dmem_addr,
                     o_dmem_wdata);
         end else begin
            e = exp_q.pop_front();
            w_got = {o_second_word, o_dmem_addr, o_dmem_wdata};
            if (w_got !== e || o_fetch !== 1'b1) begin
               n_fail++;
               $display("BAD %0t got %h want %h", $time, w_got, e);
            end
         end
      end
   end

   initial begin
      #200000;
      n_fail++;
      test_done();
   end

   initial begin
      for (int i = 0; i < 4096; i++) shadow[i] = 8'h00;
      w_exp = 8'h00;
      repeat (2) @(posedge i_clk);
      #1;
      i_arst_n = 1'b1;
      for (int i = 0; i < 6; i++) begin
         lfsr = next_rand(lfsr);
         ldw(lfsr);
         store(1'b0, {2'b00, i[5:0]}, {6'h00, i[5:0]});
      end
      send({8'h01, 8'ha5}, 1'b0);
      send(16'h0000, 1'b0);
      send(16'h0000, 1'b0);
      check(o_bank_select, 8'h05);
      store(1'b1, 8'h33, 12'h533);
      store(1'b1, 8'hff, 12'h5ff);
      store(1'b0, 8'h80, 12'hf80);
      store(1'b0, 8'h5f, 12'h05f);
      // Let the last direct store finish before the mode changes
      repeat (2) send(16'h0000, 1'b0);
      i_ext_en = 1'b1;
      i_index_base = 12'hfc0;
      store(1'b0, 8'h5f, 12'h01f);
      store(1'b0, 8'h00, 12'hfc0);
      store(1'b0, 8'h60, 12'hf60);
      store(1'b1, 8'h10, 12'h510);
      i_ext_en = 1'b0;
      lfsr = next_rand(lfsr);
      ldw(lfsr);
      store(1'b0, 8'h00, 12'h000);
      // Destinations never in counter or stack top space
      move(12'h000, 12'hfff);
      move(12'hfff, 12'h800);
      move(12'h533, 12'h000);
      move(12'hff0, 12'h456);
      move(12'h533, 12'hff0);
      store(1'b0, 8'h20, 12'h020);
      send(16'hf123, 1'b0);
      send({4'hc, 12'h533}, 1'b1);
      send(16'hf124, 1'b0);
      send({7'h37, 1'b0, 8'h30}, 1'b1);
      store(1'b0, 8'h31, 12'h031);
      repeat (4) send(16'h0000, 1'b0);
      check(o_working, w_exp);
      check(8'(exp_q.size()), 8'h00);
      test_done();
   end
endmodule // test_data_move_instruction_exec
